// ### core/fplc_pkg.sv
// constants, register map and types for the fractional-n pll calibration and lock control
//
// ****************************************************************
// register map and rule summary
// ****************************************************************
// Operation
// - n divide is integer plus num over den
// - modulator order 0 integer up to 4
// - first control write resets modulator state
// - pin select 0 readback, 1 lock
// - lock type 0 cal status, 1 vtune
// - lock delay counts 0 to 65535 state clock cycles
// - cal-status lock low during cal and delay
// - mute outputs while lock low if enabled
// - vtune locked drives high, readback state 2
// - first control write with fcal starts band cal
// - every first control write starts amplitude cal
// - no assist starts from programmed start values
// - quick recal starts from current band, programmed amplitude
// - all forces set uses host values directly
// - state clock is reference over 1,2,4,8
package fplc_pkg;
  localparam int unsigned FPLC_AW = 7;
  localparam int unsigned FPLC_DW = 16;
  // register indexes, sixteen bits each
  localparam logic [6:0] FPLC_REG_CTRL0 = 7'h00;
  localparam logic [6:0] FPLC_REG_LOCKCFG = 7'h01;
  localparam logic [6:0] FPLC_REG_LOCKDLY = 7'h02;
  localparam logic [6:0] FPLC_REG_NINT = 7'h03;
  localparam logic [6:0] FPLC_REG_NUM_HI = 7'h04;
  localparam logic [6:0] FPLC_REG_NUM_LO = 7'h05;
  localparam logic [6:0] FPLC_REG_DEN_HI = 7'h06;
  localparam logic [6:0] FPLC_REG_DEN_LO = 7'h07;
  localparam logic [6:0] FPLC_REG_CORE = 7'h08;
  localparam logic [6:0] FPLC_REG_AMP = 7'h09;
  localparam logic [6:0] FPLC_REG_BAND = 7'h0a;
  localparam logic [6:0] FPLC_REG_STATUS = 7'h0b;
  // ctrl0 fields
  localparam int unsigned FPLC_B_FCAL = 0;
  localparam int unsigned FPLC_B_ORDER_LO = 1; // 3 bits
  localparam int unsigned FPLC_B_DIV_LO = 4; // 2 bits
  localparam int unsigned FPLC_B_DLYSEL_LO = 6; // 3 bits
  // lockcfg fields
  localparam int unsigned FPLC_B_MUXSEL = 0;
  localparam int unsigned FPLC_B_LDTYPE = 1;
  localparam int unsigned FPLC_B_MUTE = 2;
  localparam int unsigned FPLC_B_QUICK = 3;
  localparam int unsigned FPLC_B_CFORCE = 4;
  localparam int unsigned FPLC_B_AFORCE = 5;
  localparam int unsigned FPLC_B_BFORCE = 6;
  // reset values
  localparam logic [15:0] FPLC_RST_CTRL0 = 16'h0000;
  localparam logic [15:0] FPLC_RST_LOCKCFG = 16'h0001;
  localparam logic [15:0] FPLC_RST_NINT = 16'h001c;
  localparam logic [15:0] FPLC_RST_DEN_LO = 16'h0001;
  localparam logic [2:0] FPLC_RST_CORE = 3'h7;
  localparam logic [8:0] FPLC_RST_AMP = 9'h12c;
  localparam logic [7:0] FPLC_RST_BAND = 8'hb7;
  localparam logic [2:0] FPLC_MAX_ORDER = 3'h4;
  localparam logic [1:0] FPLC_LOCKED = 2'h2;
  // calibration search: band steps per state clock, amplitude settle count
  localparam logic [7:0] FPLC_AMP_SETTLE = 8'h10;
  // readback frame length: 16 data bits
  localparam logic [4:0] FPLC_RB_BITS = 5'h10;
  typedef enum logic [3:0] {
    FPLC_S_IDLE = 4'h1,
    FPLC_S_BAND = 4'h2,
    FPLC_S_AMP = 4'h4,
    FPLC_S_DELAY = 4'h8
  } fplc_state_t;
endpackage : fplc_pkg

// ### core/fplc_tick_if.sv
// interface carrying the state machine clock enable from the divider
`timescale 1ns/1ns
interface fplc_tick_if;
  logic [1:0] div_sel;
  logic tick;
  modport src (input div_sel, output tick);
  modport snk (output div_sel, input tick);
endinterface : fplc_tick_if

// ### core/fplc_smclk_div.sv
// state machine clock enable: reference divided by 1, 2, 4 or 8
`timescale 1ns/1ns
module fplc_smclk_div
  import fplc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  fplc_tick_if.src tk
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] mask;
  // mask selects 2^div cycles per tick
  assign mask = 3'((4'h1 << tk.div_sel) - 4'h1);
  assign tk.tick = ((cnt_ff & mask) == mask);
  assign nxt_cnt = cnt_ff + 3'h1;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : fplc_smclk_div

// ### core/fplc_top.sv
// fractional-n pll calibration, lock detect and readback control
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
module fplc_top
  import fplc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic band_hit,
  input wire logic vtune_locked,
  input wire logic rb_start,
  input wire logic rb_sck_rise,
  input wire logic [6:0] rb_addr,
  output logic multipurpose_output_pin,
  output logic rf_out_en,
  output logic mod_reset,
  output logic [2:0] modulator_order,
  output logic [15:0] n_integer,
  output logic [31:0] frac_numerator,
  output logic [31:0] frac_denominator,
  output logic [2:0] detector_delay_select,
  output logic [2:0] osc_core_out,
  output logic [8:0] amplitude_out,
  output logic [7:0] band_out,
  output logic cal_busy
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] ctrl0_ff;
  logic [15:0] lockcfg_ff;
  logic [15:0] lock_indicator_delay_ff;
  logic [15:0] nint_ff;
  logic [31:0] num_ff;
  logic [31:0] den_ff;
  logic [2:0] osc_core_select_ff;
  logic [8:0] amplitude_start_ff;
  logic [7:0] band_start_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic wr_ctrl0;
  logic [2:0] wr_order;
  logic [2:0] wr_order_sat;
  logic [15:0] wr_den_lo;
  logic [15:0] wr_den_hi;
  logic [15:0] den_lo_keep;
  fplc_tick_if tk ();
  // write decode
  assign wr_ctrl0 = wr_stb && (addr == FPLC_REG_CTRL0);
  assign wr_order = wdata[FPLC_B_ORDER_LO +: 3];
  assign wr_order_sat = (wr_order > FPLC_MAX_ORDER) ? FPLC_MAX_ORDER : wr_order;
  // denominator of zero would be meaningless; a zero low word is stored as 1 while the high half is zero
  assign wr_den_lo = ((wdata == 16'h0000) && (den_ff[31:16] == 16'h0000)) ? 16'h0001 : wdata;
  assign wr_den_hi = wdata;
  // clearing the high half over a zero low half would leave a zero denominator
  assign den_lo_keep = ((wdata == 16'h0000) && (den_ff[15:0] == 16'h0000)) ? 16'h0001 : den_ff[15:0];
  // register file writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl0_ff <= FPLC_RST_CTRL0;
      lockcfg_ff <= FPLC_RST_LOCKCFG;
      lock_indicator_delay_ff <= 16'h0000;
      nint_ff <= FPLC_RST_NINT;
      num_ff <= 32'h0000_0000;
      den_ff <= {16'h0000, FPLC_RST_DEN_LO};
      osc_core_select_ff <= FPLC_RST_CORE;
      amplitude_start_ff <= FPLC_RST_AMP;
      band_start_ff <= FPLC_RST_BAND;
    end else if (wr_stb) begin
      case (addr)
        FPLC_REG_CTRL0: ctrl0_ff <= {wdata[15:4], wr_order_sat, wdata[0]};
        FPLC_REG_LOCKCFG: lockcfg_ff <= wdata;
        FPLC_REG_LOCKDLY: lock_indicator_delay_ff <= wdata;
        FPLC_REG_NINT: nint_ff <= wdata;
        FPLC_REG_NUM_HI: num_ff[31:16] <= wdata;
        FPLC_REG_NUM_LO: num_ff[15:0] <= wdata;
        FPLC_REG_DEN_HI: den_ff <= {wr_den_hi, den_lo_keep};
        FPLC_REG_DEN_LO: den_ff[15:0] <= wr_den_lo;
        FPLC_REG_CORE: osc_core_select_ff <= wdata[2:0];
        FPLC_REG_AMP: amplitude_start_ff <= wdata[8:0];
        FPLC_REG_BAND: band_start_ff <= wdata[7:0];
        default: ;
      endcase
    end
  end
  // modulator reset pulses on every control write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mod_reset <= 1'b1;
    end else begin
      mod_reset <= wr_ctrl0;
    end
  end
  // divider settings to the datapath
  assign modulator_order = ctrl0_ff[FPLC_B_ORDER_LO +: 3];
  assign n_integer = nint_ff;
  assign frac_numerator = num_ff;
  assign frac_denominator = den_ff;
  assign detector_delay_select = ctrl0_ff[FPLC_B_DLYSEL_LO +: 3];
  // ****************************************************************
  // state machine clock
  // ****************************************************************
  assign tk.div_sel = ctrl0_ff[FPLC_B_DIV_LO +: 2];
  fplc_smclk_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .tk(tk.src)
  );
  // ****************************************************************
  // calibration and lock delay
  // ****************************************************************
  fplc_state_t state_ff;
  fplc_state_t nxt_state;
  logic [2:0] core_ff;
  logic [8:0] amp_ff;
  logic [7:0] band_ff;
  logic [2:0] nxt_core;
  logic [8:0] nxt_amp;
  logic [7:0] nxt_band;
  logic [15:0] dly_ff;
  logic [15:0] nxt_dly;
  logic [7:0] settle_ff;
  logic [7:0] nxt_settle;
  logic all_force;
  logic quick;
  logic fcal_req;
  assign all_force = lockcfg_ff[FPLC_B_CFORCE] && lockcfg_ff[FPLC_B_AFORCE] && lockcfg_ff[FPLC_B_BFORCE];
  assign quick = lockcfg_ff[FPLC_B_QUICK];
  assign fcal_req = wr_ctrl0 && wdata[FPLC_B_FCAL];
  // calibration sequencer; a control write restarts it from any state
  always_comb begin
    nxt_state = state_ff;
    nxt_core = core_ff;
    nxt_amp = amp_ff;
    nxt_band = band_ff;
    nxt_dly = dly_ff;
    nxt_settle = settle_ff;
    if (wr_ctrl0) begin
      nxt_settle = FPLC_AMP_SETTLE;
      if (all_force) begin
        nxt_core = osc_core_select_ff;
        nxt_amp = amplitude_start_ff;
        nxt_band = band_start_ff;
        nxt_state = FPLC_S_AMP;
      end else begin
        nxt_core = osc_core_select_ff;
        nxt_amp = amplitude_start_ff;
        nxt_band = quick ? band_ff : band_start_ff;
        nxt_state = fcal_req ? FPLC_S_BAND : FPLC_S_AMP;
      end
    end else if (tk.tick) begin
      case (state_ff)
        FPLC_S_IDLE: ;
        FPLC_S_BAND: begin
          // band search steps down until the comparator reports a hit
          if (band_hit || (band_ff == 8'h00)) begin
            nxt_state = FPLC_S_AMP;
          end else begin
            nxt_band = band_ff - 8'h01;
          end
        end
        FPLC_S_AMP: begin
          if (settle_ff == 8'h00) begin
            nxt_dly = lock_indicator_delay_ff;
            nxt_state = FPLC_S_DELAY;
          end else begin
            nxt_settle = settle_ff - 8'h01;
          end
        end
        FPLC_S_DELAY: begin
          if (dly_ff == 16'h0000) begin
            nxt_state = FPLC_S_IDLE;
          end else begin
            nxt_dly = dly_ff - 16'h0001;
          end
        end
        default: nxt_state = FPLC_S_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= FPLC_S_IDLE;
      core_ff <= FPLC_RST_CORE;
      amp_ff <= FPLC_RST_AMP;
      band_ff <= FPLC_RST_BAND;
      dly_ff <= 16'h0000;
      settle_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      core_ff <= nxt_core;
      amp_ff <= nxt_amp;
      band_ff <= nxt_band;
      dly_ff <= nxt_dly;
      settle_ff <= nxt_settle;
    end
  end
  assign osc_core_out = core_ff;
  assign amplitude_out = amp_ff;
  assign band_out = band_ff;
  assign cal_busy = (state_ff == FPLC_S_BAND) || (state_ff == FPLC_S_AMP);
  // ****************************************************************
  // lock indication and muting
  // ****************************************************************
  logic lock_ind;
  logic lock_ff;
  logic [1:0] lock_state;
  // cal-status lock stays low through calibration and the delay count
  assign lock_ind = lockcfg_ff[FPLC_B_LDTYPE] ? vtune_locked : (state_ff == FPLC_S_IDLE);
  assign lock_state = vtune_locked ? FPLC_LOCKED : 2'h0;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lock_ff <= 1'b0;
      rf_out_en <= 1'b0;
    end else begin
      lock_ff <= lock_ind;
      rf_out_en <= !(lockcfg_ff[FPLC_B_MUTE] && !lock_ind);
    end
  end
  // ****************************************************************
  // readback shifter and pin mux
  // ****************************************************************
  logic [15:0] rb_sh_ff;
  logic [4:0] rb_cnt_ff;
  logic [15:0] rb_word;
  logic [15:0] status_word;
  assign status_word = {8'h00, 1'b0, lock_state, cal_busy, state_ff};
  // shared read selector for bus and serial readback
  function automatic logic [15:0] sel(input logic [6:0] a, input logic [15:0] st);
    case (a)
      FPLC_REG_CTRL0: sel = ctrl0_ff;
      FPLC_REG_LOCKCFG: sel = lockcfg_ff;
      FPLC_REG_LOCKDLY: sel = lock_indicator_delay_ff;
      FPLC_REG_NINT: sel = nint_ff;
      FPLC_REG_NUM_HI: sel = num_ff[31:16];
      FPLC_REG_NUM_LO: sel = num_ff[15:0];
      FPLC_REG_DEN_HI: sel = den_ff[31:16];
      FPLC_REG_DEN_LO: sel = den_ff[15:0];
      FPLC_REG_CORE: sel = {13'h0000, core_ff};
      FPLC_REG_AMP: sel = {7'h00, amp_ff};
      FPLC_REG_BAND: sel = {8'h00, band_ff};
      FPLC_REG_STATUS: sel = st;
      default: sel = 16'h0000;
    endcase
  endfunction : sel
  // process form so the selection follows every register the selector reads
  always_comb begin
    rb_word = sel(rb_addr, status_word);
    nxt_rdata = rd_stb ? sel(addr, status_word) : 16'h0000;
  end
  // shift msb first, one bit per serial clock rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rb_sh_ff <= 16'h0000;
      rb_cnt_ff <= 5'h00;
    end else if (rb_start) begin
      rb_sh_ff <= rb_word;
      rb_cnt_ff <= FPLC_RB_BITS;
    end else if (rb_sck_rise && (rb_cnt_ff != 5'h00)) begin
      rb_sh_ff <= {rb_sh_ff[14:0], 1'b0};
      rb_cnt_ff <= rb_cnt_ff - 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      multipurpose_output_pin <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      multipurpose_output_pin <= lockcfg_ff[FPLC_B_MUXSEL] ? lock_ff : rb_sh_ff[15];
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;
endmodule : fplc_top

// ### tb/fplc_vco_model.sv
// band comparator model on the far side of the calibration search
`timescale 1ns/1ns
module fplc_vco_model (
  input wire logic [7:0] band_out,
  input wire logic [7:0] target,
  output logic band_hit
);
  // hit once the searched band has come down to the target band
  assign band_hit = band_out <= target;
endmodule : fplc_vco_model

// ### tb/fplc_top_properties.sv
// port checks for the calibration and lock control block
`timescale 1ns/1ns
module fplc_top_properties
  import fplc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic vtune_locked,
  input wire logic multipurpose_output_pin,
  input wire logic rf_out_en,
  input wire logic mod_reset,
  input wire logic [2:0] modulator_order,
  input wire logic [31:0] frac_denominator,
  input wire logic cal_busy
);
  // ****
  // shadow of the lock configuration
  // ****
  logic [15:0] cfg_ff;
  logic rst_q_ff;
  wire ctl_wr = wr_stb && addr == FPLC_REG_CTRL0;
  wire cs_pin = cfg_ff[0] & ~cfg_ff[1];
  wire vt_pin = cfg_ff[0] & cfg_ff[1];
  wire cs_mute = cfg_ff[2] & ~cfg_ff[1];
  // follows host writes with the same one-cycle lag as the block
  always_ff @(posedge clk) begin
    rst_q_ff <= rst_b;
    if (!rst_b) begin
      cfg_ff <= FPLC_RST_LOCKCFG;
    end else if (wr_stb && addr == FPLC_REG_LOCKCFG) begin
      cfg_ff <= wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_mod_reset;
    ctl_wr |=> mod_reset;
  endproperty
  a_mod_reset: assert property (p_mod_reset) else $error("no modulator reset");
  property p_amp_cal;
    ctl_wr |=> cal_busy;
  endproperty
  a_amp_cal: assert property (p_amp_cal) else $error("no calibration start");
  property p_order_max;
    rst_q_ff |-> modulator_order <= FPLC_MAX_ORDER;
  endproperty
  a_order_max: assert property (p_order_max) else $error("order above four");
  property p_den_nonzero;
    rst_q_ff |-> frac_denominator != 32'h0;
  endproperty
  a_den_nonzero: assert property (p_den_nonzero) else $error("zero denominator");
  property p_cal_low;
    (cs_pin && cal_busy) [*3] |-> !multipurpose_output_pin;
  endproperty
  a_cal_low: assert property (p_cal_low) else $error("lock high in calibration");
  property p_mute_on;
    (cs_mute && cal_busy) [*3] |-> !rf_out_en;
  endproperty
  a_mute_on: assert property (p_mute_on) else $error("outputs not muted");
  property p_mute_off;
    (rst_q_ff && !cfg_ff[2]) [*2] |-> rf_out_en;
  endproperty
  a_mute_off: assert property (p_mute_off) else $error("muted with mute off");
  property p_vtune;
    (vt_pin && vtune_locked) [*3] |-> multipurpose_output_pin;
  endproperty
  a_vtune: assert property (p_vtune) else $error("vtune lock not shown");
endmodule : fplc_top_properties
bind fplc_top fplc_top_properties u_props (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .vtune_locked(vtune_locked), .multipurpose_output_pin(multipurpose_output_pin),
  .rf_out_en(rf_out_en), .mod_reset(mod_reset), .modulator_order(modulator_order),
  .frac_denominator(frac_denominator), .cal_busy(cal_busy));

// ### tb/tb.sv
// self-checking bench for the calibration and lock control block
`timescale 1ns/1ns
module tb
  import fplc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [6:0] rb_addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic vtune_locked = 1'b0;
  logic rb_start = 1'b0;
  logic rb_sck_rise = 1'b0;
  logic [7:0] target = 8'h00;
  logic band_hit, pin, rf_out_en, mod_reset, cal_busy;
  logic [15:0] rdata, n_integer, v;
  logic [31:0] frac_numerator, frac_denominator;
  logic [2:0] modulator_order, detector_delay_select, osc_core_out;
  logic [8:0] amplitude_out;
  logic [7:0] band_out;
  int n_mismatch = 0;
  int check_count = 0;
  int n, k;
  logic [6:0] ra [8] = '{7'h00, 7'h01, 7'h03, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h20};
  logic [15:0] rv [8] = '{16'h0000, 16'h0001, 16'h001c, 16'h0001, 16'h0007, 16'h012c, 16'h00b7, 16'h0000};
  fplc_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .band_hit(band_hit), .vtune_locked(vtune_locked), .rb_start(rb_start),
    .rb_sck_rise(rb_sck_rise), .rb_addr(rb_addr), .multipurpose_output_pin(pin), .rf_out_en(rf_out_en),
    .mod_reset(mod_reset), .modulator_order(modulator_order), .n_integer(n_integer),
    .frac_numerator(frac_numerator), .frac_denominator(frac_denominator),
    .detector_delay_select(detector_delay_select), .osc_core_out(osc_core_out),
    .amplitude_out(amplitude_out), .band_out(band_out), .cal_busy(cal_busy));
  fplc_vco_model u_vco (.band_out(band_out), .target(target), .band_hit(band_hit));
  // reference runs from time zero, ahead of any calibration
  initial begin
    forever #5 clk = ~clk;
  end
  // ****
  // access and compare tasks
  // ****
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // bounded wait for the end of calibration, cycles returned in c
  task automatic wait_idle(output int c);
    for (c = 0; c < 4000 && cal_busy !== 1'b0; c++) begin
      @(posedge clk);
    end
    if (c == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_idle
  // ****
  // main sequence
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 8; k++) begin
      rd(ra[k], v);
      chk(v, rv[k]);
    end
    for (k = 0; k < 6; k++) begin
      wr(FPLC_REG_CTRL0, (k == 5) ? 16'h000e : 16'(k << 1));
      chk(modulator_order, (k == 5) ? 4 : k);
    end
    wr(FPLC_REG_DEN_HI, 16'h0000);
    wr(FPLC_REG_DEN_LO, 16'h0000);
    chk(frac_denominator, 32'h1);
    wr(FPLC_REG_DEN_HI, 16'hffff);
    wr(FPLC_REG_DEN_LO, 16'hffff);
    wr(FPLC_REG_NUM_HI, 16'h1234);
    wr(FPLC_REG_NUM_LO, 16'ha5c3);
    chk(frac_denominator, 32'hffffffff);
    chk(frac_numerator, 32'h1234a5c3);
    wait_idle(n);
    for (k = 0; k < 4; k++) begin
      wr(FPLC_REG_CTRL0, 16'(k << 4));
      wait_idle(n);
      chk(n >= (16 << k) - 2 && n <= (18 << k), 1);
    end
    target <= 8'hb0;
    wr(FPLC_REG_LOCKDLY, 16'h0005);
    wr(FPLC_REG_LOCKCFG, 16'h0005);
    wr(FPLC_REG_NINT, 16'h0030);
    wr(FPLC_REG_CTRL0, 16'h0189);
    chk(detector_delay_select, 6);
    chk(n_integer, 32'h30);
    wait_idle(n);
    chk(band_out, 8'hb0);
    chk(osc_core_out, 7);
    for (k = 0; k < 5; k++) begin
      chk(pin, 0);
      chk(rf_out_en, 0);
      @(posedge clk);
    end
    for (k = 0; k < 40 && pin !== 1'b1; k++) begin
      @(posedge clk);
    end
    chk(pin, 1);
    repeat (2) @(posedge clk);
    chk(rf_out_en, 1);
    target <= 8'hb4;
    wr(FPLC_REG_LOCKCFG, 16'h0009);
    wr(FPLC_REG_CTRL0, 16'h0001);
    wait_idle(n);
    chk(band_out, 8'hb0);
    wr(FPLC_REG_LOCKCFG, 16'h0001);
    wr(FPLC_REG_CTRL0, 16'h0001);
    wait_idle(n);
    chk(band_out, 8'hb4);
    wr(FPLC_REG_CORE, 16'h0005);
    wr(FPLC_REG_AMP, 16'h0123);
    wr(FPLC_REG_BAND, 16'h00b2);
    wr(FPLC_REG_CTRL0, 16'h0001);
    wait_idle(n);
    chk({osc_core_out, amplitude_out, band_out}, {3'h5, 9'h123, 8'hb2});
    wr(FPLC_REG_CORE, 16'h0004);
    wr(FPLC_REG_AMP, 16'h0100);
    wr(FPLC_REG_BAND, 16'h0055);
    wr(FPLC_REG_LOCKCFG, 16'h0071);
    wr(FPLC_REG_CTRL0, 16'h0001);
    wait_idle(n);
    chk({osc_core_out, amplitude_out, band_out}, {3'h4, 9'h100, 8'h55});
    wr(FPLC_REG_LOCKCFG, 16'h0003);
    vtune_locked <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pin, 1);
    rd(FPLC_REG_STATUS, v);
    chk(v[6:5], FPLC_LOCKED);
    vtune_locked <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pin, 0);
    wr(FPLC_REG_LOCKCFG, 16'h0000);
    rb_addr <= FPLC_REG_NUM_LO;
    rb_start <= 1'b1;
    @(posedge clk);
    rb_start <= 1'b0;
    repeat (2) @(posedge clk);
    v[15] = pin;
    for (k = 14; k >= 0; k--) begin
      rb_sck_rise <= 1'b1;
      @(posedge clk);
      rb_sck_rise <= 1'b0;
      repeat (2) @(posedge clk);
      v[k] = pin;
    end
    chk(v, 16'ha5c3);
    print_verdict();
  end
endmodule : tb
